// File: rtl/hpm_bridge.sv
// Host register set: two mailboxes, indirect bridge, event register.
// Assumes host requests and firmware strobes are synchronous to clk;
// raw status bits from pins pass a three-stage synchroniser here.
//
// Functional notes
// - Inbound 64-bit mailbox written by host
// - Upper inbound word write sets firmware flag
// - Firmware clearing inbound flag sets free event
// - Inbound free event resets one, host clearable
// - Outbound mailbox read-only, upper write sets bit13
// - Host clearing bit13 sets firmware empty flag
// - 32-bit indirect target address register
// - Bridged accesses are full 32-bit words
// - Data register shows latest read or write
// - Control bit 1 starts bridged write
// - Control bit 0 starts bridged read
// - Control bit 2 busy during access
// - Control bit 3 marks refused access
// - Event register gathers all line causes
// - Masks route events to irq and request
// - Event bit 12 shows port ready
// - Event bit 11 ready and level reached
// - Event bit 7 sticky state machine fault
// - Event bit 5 sticky link fault
// - Event bit 4 state machine host irq
// - Bits 3..0 OR socket group bytes
// - Socket status word, one bit per socket
`timescale 1ns/1ps

module hpm_bridge #(
	parameter int SYNC_W = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire hpm_pkg::hpm_req_s host_req,
	output logic [31:0] host_rdata,
	output logic host_rvalid,
	input wire logic [31:0] fw_out_lo,
	input wire logic fw_out_lo_wr,
	input wire logic [31:0] fw_out_hi,
	input wire logic fw_out_hi_wr,
	input wire logic fw_in_loaded_clr,
	input wire logic fw_out_free_clr,
	input wire logic fw_sm_fault_clr,
	input wire logic fw_link_fault_clr,
	input wire logic bridge_permit,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_done,
	input wire hpm_pkg::hpm_status_s port_status,
	input wire logic [15:0] irq_mask,
	input wire logic [15:0] req_mask,
	output hpm_pkg::hpm_bridge_s bus_req,
	output logic [63:0] inbound_box,
	output logic inbound_box_loaded_irq,
	output logic outbound_box_free_irq,
	output logic host_irq_line,
	output logic host_request_line
);

	// ----------------------------------------
	// Status synchroniser (pins from the port)
	// ----------------------------------------
	logic [SYNC_W-1:0] s1_q, s2_q, s3_q, stat_q;
	logic [SYNC_W-1:0] raw;
	assign raw = {port_status.transfer_ready, port_status.level_ok,
		port_status.sm_fault, port_status.link_fault,
		port_status.sm_irq};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			stat_q <= '0;
		end else if (clk_en) begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Change accepted only when stages two and three agree
			stat_q <= (s2_q & s3_q) | (stat_q & (s2_q | s3_q));
		end
	end

	wire ready_s = stat_q[4];
	wire level_s = stat_q[3];
	wire smf_s = stat_q[2];
	wire lkf_s = stat_q[1];
	wire smi_s = stat_q[0];

	// ----------------------------------------
	// Host decode
	// ----------------------------------------
	function automatic logic hit(input hpm_pkg::hpm_req_s r,
		input logic [31:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	wire wr_addr = hit(host_req, hpm_pkg::ADDR_BRIDGE_ADDRESS);
	wire wr_data = hit(host_req, hpm_pkg::ADDR_BRIDGE_DATA);
	wire wr_ctl = hit(host_req, hpm_pkg::ADDR_BRIDGE_CONTROL);
	wire wr_event = hit(host_req, hpm_pkg::ADDR_HOST_EVENT);
	wire wr_in_lo = hit(host_req, hpm_pkg::ADDR_INBOUND_LO);
	wire wr_in_hi = hit(host_req, hpm_pkg::ADDR_INBOUND_HI);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] addr_q, data_q;
	logic [63:0] in_q, out_q;
	logic refused_q, in_loaded_q, in_free_q, out_loaded_q, out_free_q;
	logic smf_q, lkf_q, smi_q;
	hpm_pkg::hpm_state_e st_q;

	wire idle = (st_q == hpm_pkg::HPM_IDLE);
	wire go_wr = wr_ctl && host_req.wdata[hpm_pkg::CTL_WRITE_BIT] && idle;
	wire go_rd = wr_ctl && host_req.wdata[hpm_pkg::CTL_READ_BIT] && idle
		&& !go_wr;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_q <= hpm_pkg::WORD_ZERO;
		end else if (clk_en && wr_addr) begin
			addr_q <= host_req.wdata;
		end
	end

	// later of host write or bridged read wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_q <= hpm_pkg::WORD_ZERO;
		end else if (clk_en) begin
			if (st_q == hpm_pkg::HPM_READ && bus_done) begin
				data_q <= bus_rdata;
			end else if (wr_data) begin
				data_q <= host_req.wdata;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= hpm_pkg::HPM_IDLE;
			refused_q <= 1'b0;
		end else if (clk_en) begin
			case (st_q)
				hpm_pkg::HPM_IDLE: begin
					if ((go_rd || go_wr) && !bridge_permit) begin
						refused_q <= 1'b1;
					end else if (go_wr) begin
						refused_q <= 1'b0;
						st_q <= hpm_pkg::HPM_WRITE;
					end else if (go_rd) begin
						refused_q <= 1'b0;
						st_q <= hpm_pkg::HPM_READ;
					end
				end
				default: begin
					if (bus_done) begin
						st_q <= hpm_pkg::HPM_IDLE;
					end
				end
			endcase
		end
	end

	// free event resets set, cleared by load or host
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_q <= {hpm_pkg::WORD_ZERO, hpm_pkg::WORD_ZERO};
			in_loaded_q <= 1'b0;
			in_free_q <= hpm_pkg::EVENT_RESET[hpm_pkg::EV_IN_FREE_BIT];
		end else if (clk_en) begin
			if (wr_in_lo) begin
				in_q[31:0] <= host_req.wdata;
			end
			if (wr_in_hi) begin
				in_q[63:32] <= host_req.wdata;
			end
			// Set wins over a clear in the same cycle
			in_loaded_q <= wr_in_hi || (in_loaded_q && !fw_in_loaded_clr);
			if (fw_in_loaded_clr && in_loaded_q && !wr_in_hi) begin
				in_free_q <= 1'b1;
			end else if (wr_in_hi || (wr_event &&
				host_req.wdata[hpm_pkg::EV_IN_FREE_BIT])) begin
				in_free_q <= 1'b0;
			end
		end
	end

	// host clear sets firmware empty flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_q <= {hpm_pkg::WORD_ZERO, hpm_pkg::WORD_ZERO};
			out_loaded_q <= 1'b0;
			out_free_q <= 1'b0;
		end else if (clk_en) begin
			if (fw_out_lo_wr) begin
				out_q[31:0] <= fw_out_lo;
			end
			if (fw_out_hi_wr) begin
				out_q[63:32] <= fw_out_hi;
			end
			if (fw_out_hi_wr) begin
				out_loaded_q <= 1'b1;
			end else if (wr_event &&
				host_req.wdata[hpm_pkg::EV_OUT_LOADED_BIT]) begin
				out_loaded_q <= 1'b0;
			end
			out_free_q <= (wr_event && out_loaded_q && !fw_out_hi_wr &&
				host_req.wdata[hpm_pkg::EV_OUT_LOADED_BIT]) ||
				(out_free_q && !fw_out_free_clr);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			smf_q <= 1'b0;
			lkf_q <= 1'b0;
			smi_q <= 1'b0;
		end else if (clk_en) begin
			smf_q <= smf_s || (smf_q && !fw_sm_fault_clr);
			lkf_q <= lkf_s || (lkf_q && !fw_link_fault_clr);
			smi_q <= smi_s || (smi_q && !(wr_event &&
				host_req.wdata[hpm_pkg::EV_SM_IRQ_BIT]));
		end
	end

	// ----------------------------------------
	// Event assembly and readback
	// ----------------------------------------
	logic [15:0] ev;
	assign ev = {1'b0, in_free_q, out_loaded_q, ready_s,
		ready_s && level_s, 3'b000, smf_q, 1'b0, lkf_q, smi_q,
		|port_status.group_b[15:8], |port_status.group_b[7:0],
		|port_status.group_a[15:8], |port_status.group_a[7:0]};

	logic [15:0] ctl;
	assign ctl = {12'h000, refused_q, !idle,
		st_q == hpm_pkg::HPM_WRITE, st_q == hpm_pkg::HPM_READ};

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = hpm_pkg::WORD_ZERO;
		if (host_req.addr == hpm_pkg::ADDR_BRIDGE_ADDRESS) begin
			rd_mux = addr_q;
		end else if (host_req.addr == hpm_pkg::ADDR_BRIDGE_DATA) begin
			rd_mux = data_q;
		end else if (host_req.addr == hpm_pkg::ADDR_BRIDGE_CONTROL) begin
			rd_mux = {hpm_pkg::HALF_ZERO, ctl};
		end else if (host_req.addr == hpm_pkg::ADDR_HOST_EVENT) begin
			rd_mux = {hpm_pkg::HALF_ZERO, ev};
		end else if (host_req.addr == hpm_pkg::ADDR_OUTBOUND_LO) begin
			rd_mux = out_q[31:0];
		end else if (host_req.addr == hpm_pkg::ADDR_OUTBOUND_HI) begin
			rd_mux = out_q[63:32];
		end else if (host_req.addr == hpm_pkg::ADDR_SOCKET_STATUS) begin
			rd_mux = port_status.sockets;
		end else if (host_req.addr == hpm_pkg::ADDR_INBOUND_LO) begin
			rd_mux = in_q[31:0];
		end else if (host_req.addr == hpm_pkg::ADDR_INBOUND_HI) begin
			rd_mux = in_q[63:32];
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_rdata <= hpm_pkg::WORD_ZERO;
			host_rvalid <= 1'b0;
			bus_req <= '0;
			inbound_box <= {hpm_pkg::WORD_ZERO, hpm_pkg::WORD_ZERO};
			inbound_box_loaded_irq <= 1'b0;
			outbound_box_free_irq <= 1'b0;
			host_irq_line <= 1'b0;
			host_request_line <= 1'b0;
		end else if (clk_en) begin
			host_rvalid <= host_req.rd;
			if (host_req.rd) begin
				host_rdata <= rd_mux;
			end
			// One-cycle strobe; target answers with a one-cycle done pulse
			bus_req.rd <= go_rd && bridge_permit;
			bus_req.wr <= go_wr && bridge_permit;
			bus_req.addr <= addr_q;
			bus_req.wdata <= data_q;
			inbound_box <= in_q;
			inbound_box_loaded_irq <= in_loaded_q;
			outbound_box_free_irq <= out_free_q;
			host_irq_line <= |(ev & irq_mask);
			host_request_line <= |(ev & req_mask);
		end
	end

endmodule

// File: include/hpm_pkg.sv
// Package for the host port mailbox and register bridge.
// Assumes a single 50 MHz system clock; shared by rtl and bench.
package hpm_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [31:0] ADDR_BRIDGE_ADDRESS = 32'hE0017E3C;
	localparam logic [31:0] ADDR_BRIDGE_DATA = 32'hE0017E40;
	localparam logic [31:0] ADDR_BRIDGE_CONTROL = 32'hE0017E44;
	localparam logic [31:0] ADDR_HOST_EVENT = 32'hE0017E48;
	localparam logic [31:0] ADDR_OUTBOUND_LO = 32'hE0017E4C;
	localparam logic [31:0] ADDR_OUTBOUND_HI = 32'hE0017E50;
	localparam logic [31:0] ADDR_SOCKET_STATUS = 32'hE0017E54;
	localparam logic [31:0] ADDR_INBOUND_LO = 32'hE0017E34;
	localparam logic [31:0] ADDR_INBOUND_HI = 32'hE0017E38;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTL_READ_BIT = 0;
	localparam int CTL_WRITE_BIT = 1;
	localparam int CTL_BUSY_BIT = 2;
	localparam int CTL_REFUSED_BIT = 3;
	localparam int EV_WAKE_BIT = 15;
	localparam int EV_IN_FREE_BIT = 14;
	localparam int EV_OUT_LOADED_BIT = 13;
	localparam int EV_READY_BIT = 12;
	localparam int EV_LEVEL_BIT = 11;
	localparam int EV_SM_FAULT_BIT = 7;
	localparam int EV_LINK_FAULT_BIT = 5;
	localparam int EV_SM_IRQ_BIT = 4;

	// ----------------------------------------
	// Reset values and widths
	// ----------------------------------------
	localparam logic [15:0] EVENT_RESET = 16'h4000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [15:0] HALF_ZERO = 16'h0000;
	localparam int WORD_W = 32;
	localparam int EVENT_W = 16;

	// Host-side register access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [31:0] addr;
		logic [31:0] wdata;
	} hpm_req_s;

	// Internal register bus request toward the on-chip space
	typedef struct packed {
		logic rd;
		logic wr;
		logic [31:0] addr;
		logic [31:0] wdata;
	} hpm_bridge_s;

	// Status inputs from the rest of the port
	typedef struct packed {
		logic transfer_ready;
		logic level_ok;
		logic sm_fault;
		logic link_fault;
		logic sm_irq;
		logic [15:0] group_a;
		logic [15:0] group_b;
		logic [31:0] sockets;
	} hpm_status_s;

	typedef enum logic [1:0] {
		HPM_IDLE,
		HPM_READ,
		HPM_WRITE
	} hpm_state_e;

endpackage

// File: sim/hpm_bridge_monitor.sv
// Port checker for hpm_bridge, attached by bind.
// Assumes clk_en gates every state change of the design.
`timescale 1ns/1ps
module hpm_bridge_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire hpm_pkg::hpm_req_s host_req,
	input wire logic host_rvalid,
	input wire logic bridge_permit,
	input wire logic bus_done,
	input wire logic [15:0] irq_mask,
	input wire logic [15:0] req_mask,
	input wire hpm_pkg::hpm_bridge_s bus_req,
	input wire logic [63:0] inbound_box,
	input wire logic inbound_box_loaded_irq,
	input wire logic host_irq_line,
	input wire logic host_request_line
);
	// ----------------------------------------
	// Bridge occupancy seen from the ports
	// ----------------------------------------
	logic busy_q;
	logic busy_d;
	logic strobe;
	logic ctl_wr;
	logic hi_wr;
	assign strobe = bus_req.rd | bus_req.wr;
	assign busy_d = strobe | (busy_q & ~bus_done);
	assign ctl_wr = clk_en & host_req.wr & ~busy_q & ~strobe
		& (host_req.addr == hpm_pkg::ADDR_BRIDGE_CONTROL);
	assign hi_wr = clk_en & host_req.wr
		& (host_req.addr == hpm_pkg::ADDR_INBOUND_HI);
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			busy_q <= 1'b0;
		else if (clk_en)
			busy_q <= busy_d;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_RVALID: assert property (clk_en && host_req.rd |=> host_rvalid)
		else $error("read answer missing");
	// Mailbox and its copy are two flops deep, hence two cycles
	AST_IN_HI: assert property (hi_wr |-> ##2 (inbound_box_loaded_irq
		&& inbound_box[63:32] == $past(host_req.wdata, 2)))
		else $error("inbound upper word not loaded");
	AST_WR_TRIG: assert property (ctl_wr && host_req.wdata[1]
		&& bridge_permit |=> bus_req.wr && !bus_req.rd)
		else $error("bridged write not started");
	AST_RD_TRIG: assert property (ctl_wr && bridge_permit
		&& host_req.wdata[1:0] == 2'h1 |=> bus_req.rd && !bus_req.wr)
		else $error("bridged read not started");
	AST_REFUSE: assert property (ctl_wr && !bridge_permit
		&& host_req.wdata[1:0] != 2'h0 |=> !strobe)
		else $error("refused access reached the bus");
	AST_STROBE: assert property (strobe && clk_en |=> !strobe)
		else $error("bus strobe longer than one cycle");
	AST_IRQ_MASK: assert property ($past(irq_mask) == 16'h0000
		&& $past(clk_en) |-> !host_irq_line)
		else $error("irq line raised with mask clear");
	AST_REQ_MASK: assert property ($past(req_mask) == 16'h0000
		&& $past(clk_en) |-> !host_request_line)
		else $error("request line raised with mask clear");
endmodule

bind hpm_bridge hpm_bridge_monitor hpm_bridge_monitor_i (.clk, .rst,
	.clk_en, .host_req, .host_rvalid, .bridge_permit, .bus_done,
	.irq_mask, .req_mask, .bus_req, .inbound_box,
	.inbound_box_loaded_irq, .host_irq_line, .host_request_line);

// File: sim/hpm_target.sv
// Behavioural register target behind the bridge.
// Assumes one access at a time; answers after one or five cycles.
`timescale 1ns/1ps
module hpm_target (
	input wire logic clk,
	input wire logic rst,
	input wire hpm_pkg::hpm_bridge_s bus_req,
	input wire logic slow,
	output logic [31:0] bus_rdata,
	output logic bus_done
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] a_q;
	logic rd_q;
	int n;
	// ----------------------------------------
	// Access engine
	// ----------------------------------------
	// Idle data toggles so a stale capture is caught
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			n = 0;
			bus_done <= 1'b0;
			bus_rdata <= 32'h0000_0000;
		end else if (bus_req.rd || bus_req.wr) begin
			if (bus_req.wr)
				mem[bus_req.addr] = bus_req.wdata;
			a_q = bus_req.addr;
			rd_q = bus_req.rd;
			n = slow ? 5 : 1;
			bus_done <= 1'b0;
			bus_rdata <= ~bus_rdata;
		end else begin
			bus_done <= (n == 1);
			bus_rdata <= (n == 1 && rd_q) ? mem[a_q] : ~bus_rdata;
			if (n > 0)
				n = n - 1;
		end
	end
endmodule

// File: sim/hpm_bridge_tb.sv
// Self-checking bench for hpm_bridge with a behavioural target.
// Assumes the package register map; inputs move on falling edges.
`timescale 1ns/1ps
module hpm_bridge_tb;
	logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, slow = 1'b0;
	hpm_pkg::hpm_req_s host_req = '0;
	hpm_pkg::hpm_status_s port_status = '0, po;
	hpm_pkg::hpm_bridge_s bus_req;
	logic [31:0] fw_out_lo = '0, fw_out_hi = '0, host_rdata, bus_rdata;
	logic fw_out_lo_wr = 0, fw_out_hi_wr = 0, fw_in_loaded_clr = 0;
	logic fw_out_free_clr = 0, fw_sm_fault_clr = 0, fw_link_fault_clr = 0;
	logic bridge_permit = 0, host_rvalid, bus_done;
	logic inbound_box_loaded_irq, outbound_box_free_irq;
	logic host_irq_line, host_request_line;
	logic [15:0] irq_mask = '0, req_mask = '0, e;
	logic [63:0] inbound_box;
	logic [31:0] a, d0, d1, s;
	logic [31:0] shadow [logic [31:0]];
	logic [95:0] r96;
	integer seed = 36301, errors = 0, n_tests = 0;

	hpm_bridge hpm_bridge_i (.clk, .rst, .clk_en, .host_req, .host_rdata,
		.host_rvalid, .fw_out_lo, .fw_out_lo_wr, .fw_out_hi, .fw_out_hi_wr,
		.fw_in_loaded_clr, .fw_out_free_clr, .fw_sm_fault_clr,
		.fw_link_fault_clr, .bridge_permit, .bus_rdata, .bus_done,
		.port_status, .irq_mask, .req_mask, .bus_req, .inbound_box,
		.inbound_box_loaded_irq, .outbound_box_free_irq, .host_irq_line,
		.host_request_line);
	hpm_target hpm_target_i (.clk, .rst, .bus_req, .slow, .bus_rdata,
		.bus_done);

	initial begin
		forever #10 clk = ~clk;
	end

	// ----------------------------------------
	// Bench tasks and expectations
	// ----------------------------------------
	task automatic chk(input string nm, input logic [63:0] seen,
		input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hw(input logic [31:0] ad, input logic [31:0] d);
		@(negedge clk);
		host_req = '{1'b0, 1'b1, ad, d};
		@(negedge clk);
		host_req.wr = 1'b0;
	endtask
	task automatic hr(input logic [31:0] ad, output logic [31:0] d);
		@(negedge clk);
		host_req = '{1'b1, 1'b0, ad, 32'h0000_0000};
		@(negedge clk);
		host_req.rd = 1'b0;
		chk("rvalid", host_rvalid, 1'b1);
		d = host_rdata;
	endtask
	task automatic rc(input string nm, input logic [31:0] ad,
		input logic [63:0] ex);
		logic [31:0] d;
		hr(ad, d);
		chk(nm, d, ex);
	endtask
	task automatic pulse(ref logic sig);
		@(negedge clk);
		sig = 1'b1;
		@(negedge clk);
		sig = 1'b0;
	endtask
	// Polls are bounded so a stuck busy bit ends as a mismatch
	// wait for idle
	task automatic idle_wait(output logic [31:0] st);
		hr(hpm_pkg::ADDR_BRIDGE_CONTROL, st);
		chk("busy", st[2], bridge_permit);
		for (int k = 0; k < 20 && st[2] !== 1'b0; k++)
			hr(hpm_pkg::ADDR_BRIDGE_CONTROL, st);
		chk("control", st[3:0], {!bridge_permit, 3'h0});
	endtask
	function automatic logic [15:0] ev_exp(hpm_pkg::hpm_status_s p);
		return {3'h0, p.transfer_ready, p.transfer_ready & p.level_ok,
			3'h0, p.sm_fault, 1'b0, p.link_fault, p.sm_irq,
			|p.group_b[15:8], |p.group_b[7:0],
			|p.group_a[15:8], |p.group_a[7:0]};
	endfunction
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#400000;
		errors++;
		conclude();
	end

	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		rc("address", hpm_pkg::ADDR_BRIDGE_ADDRESS, 0);
		rc("data", hpm_pkg::ADDR_BRIDGE_DATA, 0);
		rc("control", hpm_pkg::ADDR_BRIDGE_CONTROL, 0);
		rc("event", hpm_pkg::ADDR_HOST_EVENT, 16'h4000);
		rc("outbound", hpm_pkg::ADDR_OUTBOUND_HI, 0);
		rc("unmapped", 32'hE0017E58, 0);
		$display("test reset done");
		d0 = $random(seed);
		d1 = $random(seed);
		hw(hpm_pkg::ADDR_INBOUND_LO, d0);
		hw(hpm_pkg::ADDR_INBOUND_HI, d1);
		@(negedge clk);
		chk("inbound", inbound_box, {d1, d0});
		chk("loaded", inbound_box_loaded_irq, 1'b1);
		rc("event", hpm_pkg::ADDR_HOST_EVENT, 0);
		pulse(fw_in_loaded_clr);
		rc("event", hpm_pkg::ADDR_HOST_EVENT, 16'h4000);
		chk("loaded", inbound_box_loaded_irq, 1'b0);
		hw(hpm_pkg::ADDR_HOST_EVENT, 32'h0000_4000);
		rc("event", hpm_pkg::ADDR_HOST_EVENT, 0);
		fw_out_lo = $random(seed);
		fw_out_hi = $random(seed);
		pulse(fw_out_lo_wr);
		pulse(fw_out_hi_wr);
		hw(hpm_pkg::ADDR_OUTBOUND_LO, ~fw_out_lo);
		rc("out lo", hpm_pkg::ADDR_OUTBOUND_LO, fw_out_lo);
		rc("out hi", hpm_pkg::ADDR_OUTBOUND_HI, fw_out_hi);
		rc("event", hpm_pkg::ADDR_HOST_EVENT, 16'h2000);
		hw(hpm_pkg::ADDR_HOST_EVENT, 32'h0000_2000);
		@(negedge clk);
		chk("out free", outbound_box_free_irq, 1'b1);
		rc("event", hpm_pkg::ADDR_HOST_EVENT, 0);
		pulse(fw_out_free_clr);
		// Clock enable low: a host write must not land
		clk_en = 1'b0;
		hw(hpm_pkg::ADDR_INBOUND_HI, ~d1);
		clk_en = 1'b1;
		rc("frozen", hpm_pkg::ADDR_INBOUND_HI, d1);
		chk("frozen", inbound_box_loaded_irq, 1'b0);
		chk("out free", outbound_box_free_irq, 1'b0);
		$display("test mailboxes done");
		for (int i = 0; i < 8; i++) begin
			a = $random(seed) & 32'h0000_001C;
			d0 = $random(seed);
			slow = $random(seed);
			bridge_permit = (i != 3);
			hw(hpm_pkg::ADDR_BRIDGE_ADDRESS, a);
			rc("address", hpm_pkg::ADDR_BRIDGE_ADDRESS, a);
			hw(hpm_pkg::ADDR_BRIDGE_DATA, d0);
			rc("data", hpm_pkg::ADDR_BRIDGE_DATA, d0);
			hw(hpm_pkg::ADDR_BRIDGE_CONTROL, i[0] ? 32'h3 : 32'h2);
			idle_wait(s);
			if (bridge_permit)
				shadow[a] = d0;
			hw(hpm_pkg::ADDR_BRIDGE_CONTROL, 32'h0000_0001);
			idle_wait(s);
			d1 = bridge_permit ? shadow[a] : d0;
			rc("bridged", hpm_pkg::ADDR_BRIDGE_DATA, d1);
		end
		$display("test bridge done");
		for (int i = 0; i < 4; i++) begin
			r96 = {$random(seed), $random(seed), $random(seed)};
			port_status = r96[68:0];
			irq_mask = r96[84:69];
			req_mask = r96[95:80];
			repeat (6) @(negedge clk);
			e = ev_exp(port_status);
			rc("event", hpm_pkg::ADDR_HOST_EVENT, e);
			rc("sockets", hpm_pkg::ADDR_SOCKET_STATUS, port_status.sockets);
			chk("irq line", host_irq_line, |(e & irq_mask));
			chk("req line", host_request_line, |(e & req_mask));
			po = port_status;
			port_status = '0;
			repeat (6) @(negedge clk);
			e = {8'h00, po.sm_fault, 1'b0, po.link_fault, po.sm_irq, 4'h0};
			rc("sticky", hpm_pkg::ADDR_HOST_EVENT, e);
			pulse(fw_sm_fault_clr);
			pulse(fw_link_fault_clr);
			hw(hpm_pkg::ADDR_HOST_EVENT, 32'h0000_0010);
			rc("cleared", hpm_pkg::ADDR_HOST_EVENT, 0);
		end
		$display("test events done");
		conclude();
	end
endmodule
